// File: inc/pcr_pkg.sv
// Shared constants and carriers for the port capability register slice
package pcr_pkg;

    // Register byte offsets
    localparam logic [11:0] PCR_OFS_MSG_UPPER = 12'h050;
    localparam logic [11:0] PCR_OFS_MSG_DATA = 12'h054;
    localparam logic [11:0] PCR_OFS_EXP_CAP = 12'h068;
    localparam logic [11:0] PCR_OFS_DEV_CAP = 12'h06c;

    // Reset values
    localparam logic [31:0] PCR_RST_MSG_UPPER = 32'h0000_0000;
    localparam logic [15:0] PCR_RST_MSG_DATA = 16'h0000;

    // Express capability header fields
    localparam logic [7:0] PCR_CAP_ID = 8'h10;
    localparam logic [7:0] PCR_RST_NEXT_PTR = 8'ha4;
    localparam logic [3:0] PCR_CAP_VERSION = 4'h2;
    localparam logic [3:0] PCR_TYPE_UP = 4'h5;
    localparam logic [3:0] PCR_TYPE_DOWN = 4'h6;
    localparam logic [4:0] PCR_INT_MSG_NUM = 5'h00;
    localparam int PCR_POS_NEXT_PTR = 8;
    localparam int PCR_POS_VERSION = 16;
    localparam int PCR_POS_TYPE = 20;
    localparam int PCR_POS_SLOT = 24;
    localparam int PCR_POS_MSG_NUM = 25;

    // Device capabilities fields
    localparam logic [2:0] PCR_MPS_128 = 3'h0;
    localparam logic [2:0] PCR_MPS_256 = 3'h1;
    localparam logic [2:0] PCR_MPS_512 = 3'h2;
    localparam logic [2:0] PCR_RST_MPS = PCR_MPS_256;
    localparam logic PCR_RST_RBER = 1'b1;
    localparam logic PCR_RST_SLOT_IMPL = 1'b1;
    localparam int PCR_POS_PHANTOM = 3;
    localparam int PCR_POS_EXT_TAG = 5;
    localparam int PCR_POS_L0S_LAT = 6;
    localparam int PCR_POS_L1_LAT = 9;
    localparam int PCR_POS_RBER = 15;
    localparam int PCR_POS_PWR_VAL = 18;
    localparam int PCR_POS_PWR_SCALE = 26;

    // Configuration access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pcr_cfg_req_t;

    // Preload of loadable fields
    typedef struct packed {
        logic valid;
        logic [7:0] next_ptr;
        logic slot_impl;
        logic [2:0] mps;
        logic rber;
    } pcr_preload_t;

    // Captured slot power limit message
    typedef struct packed {
        logic valid;
        logic [7:0] value;
        logic [1:0] scale;
    } pcr_pwr_msg_t;

endpackage

// File: src/pcr_word_reg.sv
`timescale 1ns/100ps
`default_nettype none
// One byte-enabled read-write word with reset value
module pcr_word_reg
    import pcr_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Write side
    input wire logic wr_en,
    input wire logic [3:0] be,
    input wire logic [31:0] wdata,
    // Stored value
    output logic [WIDTH-1:0] value_q
);

    // Byte lane merge; lanes above WIDTH are dropped
    function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old,
                                               input logic [3:0] lanes,
                                               input logic [31:0] data);
        logic [WIDTH-1:0] res;
        res = old;
        for (int i = 0; i < WIDTH; i++) begin
            if (lanes[i / 8]) begin
                res[i] = data[i];
            end
        end
        return res;
    endfunction

    // Storage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= RST_VAL;
        end else if (wr_en) begin
            value_q <= merge(value_q, be, wdata);
        end
    end

endmodule // pcr_word_reg
`default_nettype wire

// File: src/pcr_port_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Upper message address, 32-bit read-write, resets to zero, used with 64-bit MSI.
// - Message data, 16-bit read-write in low half, resets to zero.
// - Header low byte is capability id 10h; next byte pointer defaults A4h.
// - Capability version field reads constant 2.
// - Port type reads 0101b upstream, 0110b downstream; read-only.
// - Slot implemented reads zero upstream, defaults one downstream.
// - Interrupt message number field reads all zeros.
// - Max payload supported codes 0..2 for 128..512 bytes, default 256 code.
// - Phantom functions supported reads zero.
// - Extended tag supported reads zero.
// - Both endpoint acceptable latency fields read zero.
// - Role-based error reporting defaults one, preload may override.
// - Upstream only captures slot power value and scale from message; else zero.
module pcr_port_regs
    import pcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Port role strap, static
    input wire logic is_upstream,
    // Configuration access
    input wire pcr_cfg_req_t cfg_req,
    output logic [31:0] cfg_rdata_q,
    output logic cfg_ack_q,
    // Preload and message capture
    input wire pcr_preload_t preload,
    input wire pcr_pwr_msg_t pwr_msg,
    // MSI 64-bit capability, effective message address upper half and message data
    input wire logic msi_64bit_cap,
    output logic [31:0] msi_addr_upper_q,
    output logic [15:0] msi_data_q
);

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] up_sync_q;
    logic up_q;
    logic wr_upper;
    logic wr_data;
    logic [31:0] upper_q;
    logic [15:0] data_q;
    logic [7:0] next_ptr_q;
    logic slot_impl_q;
    logic [2:0] mps_q;
    logic rber_q;
    logic [7:0] pwr_val_q;
    logic [1:0] pwr_scale_q;
    logic [31:0] exp_cap;
    logic [31:0] dev_cap;
    logic [31:0] rdata_d;

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Strap synchroniser
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            up_sync_q <= 2'h0;
        end else begin
            up_sync_q <= {up_sync_q[0], is_upstream};
        end
    end
    assign up_q = up_sync_q[1];

    // Write strobes for the read-write words
    assign wr_upper = cfg_req.wr && (cfg_req.addr == PCR_OFS_MSG_UPPER);
    assign wr_data = cfg_req.wr && (cfg_req.addr == PCR_OFS_MSG_DATA);

    // Upper message address
    pcr_word_reg #(.WIDTH(32), .RST_VAL(PCR_RST_MSG_UPPER)) u_upper (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_en(wr_upper),
        .be(cfg_req.be),
        .wdata(cfg_req.wdata),
        .value_q(upper_q)
    );

    // Message data, upper lanes dropped
    pcr_word_reg #(.WIDTH(16), .RST_VAL(PCR_RST_MSG_DATA)) u_data (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_en(wr_data),
        .be(cfg_req.be),
        .wdata(cfg_req.wdata),
        .value_q(data_q)
    );

    // Loadable fields change only by preload
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            next_ptr_q <= PCR_RST_NEXT_PTR;
            slot_impl_q <= PCR_RST_SLOT_IMPL;
            mps_q <= PCR_RST_MPS;
            rber_q <= PCR_RST_RBER;
        end else if (preload.valid) begin
            next_ptr_q <= preload.next_ptr;
            slot_impl_q <= preload.slot_impl;
            // Codes above 512 bytes fall back to 256
            mps_q <= (preload.mps > PCR_MPS_512) ? PCR_RST_MPS : preload.mps;
            rber_q <= preload.rber;
        end
    end

    // Slot power capture, upstream only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwr_val_q <= 8'h00;
            pwr_scale_q <= 2'h0;
        end else if (!up_q) begin
            pwr_val_q <= 8'h00;
            pwr_scale_q <= 2'h0;
        end else if (pwr_msg.valid) begin
            pwr_val_q <= pwr_msg.value;
            pwr_scale_q <= pwr_msg.scale;
        end
    end

    // Read images; reserved bits zero
    always_comb begin
        exp_cap = 32'h0000_0000;
        exp_cap[7:0] = PCR_CAP_ID;
        exp_cap[PCR_POS_NEXT_PTR +: 8] = next_ptr_q;
        exp_cap[PCR_POS_VERSION +: 4] = PCR_CAP_VERSION;
        exp_cap[PCR_POS_TYPE +: 4] = up_q ? PCR_TYPE_UP : PCR_TYPE_DOWN;
        exp_cap[PCR_POS_SLOT] = up_q ? 1'b0 : slot_impl_q;
        exp_cap[PCR_POS_MSG_NUM +: 5] = PCR_INT_MSG_NUM;
        dev_cap = 32'h0000_0000;
        dev_cap[2:0] = mps_q;
        dev_cap[PCR_POS_PHANTOM +: 2] = 2'h0;
        dev_cap[PCR_POS_EXT_TAG] = 1'b0;
        dev_cap[PCR_POS_L0S_LAT +: 3] = 3'h0;
        dev_cap[PCR_POS_L1_LAT +: 3] = 3'h0;
        dev_cap[PCR_POS_RBER] = rber_q;
        dev_cap[PCR_POS_PWR_VAL +: 8] = pwr_val_q;
        dev_cap[PCR_POS_PWR_SCALE +: 2] = pwr_scale_q;
    end

    // Read decode; unmapped reads zero
    always_comb begin
        if (cfg_req.addr == PCR_OFS_MSG_UPPER) begin
            rdata_d = upper_q;
        end else if (cfg_req.addr == PCR_OFS_MSG_DATA) begin
            rdata_d = {16'h0000, data_q};
        end else if (cfg_req.addr == PCR_OFS_EXP_CAP) begin
            rdata_d = exp_cap;
        end else if (cfg_req.addr == PCR_OFS_DEV_CAP) begin
            rdata_d = dev_cap;
        end else begin
            rdata_d = 32'h0000_0000;
        end
    end

    // Registered answer, one cycle after request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata_q <= 32'h0000_0000;
            cfg_ack_q <= 1'b0;
        end else begin
            cfg_ack_q <= cfg_req.rd || cfg_req.wr;
            cfg_rdata_q <= cfg_req.rd ? rdata_d : 32'h0000_0000;
        end
    end

    // MSI outputs; upper half only with 64-bit capability
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            msi_addr_upper_q <= 32'h0000_0000;
            msi_data_q <= 16'h0000;
        end else begin
            msi_addr_upper_q <= msi_64bit_cap ? upper_q : 32'h0000_0000;
            msi_data_q <= data_q;
        end
    end

    // Assertions
    sequence full_write_upper_s;
        cfg_req.wr && cfg_req.addr == PCR_OFS_MSG_UPPER && cfg_req.be == 4'hf;
    endsequence

    upper_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        full_write_upper_s |=> upper_q == $past(cfg_req.wdata))
        else $error("upper address write lost");
    data_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg_ack_q && $past(cfg_req.rd) && $past(cfg_req.addr) == PCR_OFS_MSG_DATA
        |-> cfg_rdata_q[31:16] == 16'h0000)
        else $error("message data high half not zero");
    cap_id_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exp_cap[7:0] == 8'h10 && exp_cap[19:16] == 4'h2)
        else $error("capability id or version wrong");
    port_type_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        exp_cap[23:20] == (up_q ? 4'h5 : 4'h6))
        else $error("port type wrong");
    slot_up_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        up_q |-> !exp_cap[24] && exp_cap[31:25] == 7'h00)
        else $error("slot bit set on upstream port");
    devcap_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        dev_cap[14:3] == 12'h000 && dev_cap[17:16] == 2'h0 && dev_cap[31:28] == 4'h0)
        else $error("fixed device capability bits not zero");
    mps_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        dev_cap[2:0] <= 3'h2)
        else $error("payload code out of range");
    pwr_down_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !up_q ##1 !up_q |-> dev_cap[27:18] == 10'h000)
        else $error("power limit captured on downstream port");
    ro_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !preload.valid |=> $stable(next_ptr_q) && $stable(rber_q))
        else $error("loadable field changed without preload");
    ack_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg_req.rd |=> cfg_ack_q)
        else $error("read not answered");

endmodule // pcr_port_regs
`default_nettype wire

// File: dv/pcr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side that issues configuration accesses, one pulse each
module pcr_host_model
    import pcr_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Request and answer
    output var pcr_cfg_req_t cfg_req,
    input wire logic [31:0] cfg_rdata_q,
    input wire logic cfg_ack_q
);
    initial cfg_req = '0;

    // One access: request up for one edge, answer taken one cycle later
    task automatic access(input logic wr, input logic [11:0] addr, input logic [3:0] be,
                          input logic [31:0] wdata, output logic [31:0] rdata,
                          output logic ack);
        @(negedge clk_sys);
        cfg_req = {~wr, wr, addr, be, wdata};
        @(negedge clk_sys);
        rdata = cfg_rdata_q;
        ack = cfg_ack_q;
        // Idle fields scrambled so stale values never look valid
        cfg_req = {2'b00, ~addr, ~be, ~wdata};
    endtask
endmodule // pcr_host_model
`default_nettype wire

// File: dv/pcr_port_capability_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pcr_port_capability_regs_tb_top;
    import pcr_pkg::*;
    logic clk_sys, reset_n, is_upstream, msi_64bit_cap, ack;
    pcr_cfg_req_t cfg_req;
    pcr_preload_t preload;
    pcr_pwr_msg_t pwr_msg;
    logic [31:0] cfg_rdata_q, msi_addr_upper_q, rd, r, wd, m_up, m_dat;
    logic [15:0] msi_data_q;
    logic cfg_ack_q;
    logic [3:0] be;
    int bad_count = 0;
    int tests_run = 0;
    int seed = 53264;

    pcr_port_regs pcr_port_regs_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .is_upstream(is_upstream), .cfg_req(cfg_req), .cfg_rdata_q(cfg_rdata_q),
        .cfg_ack_q(cfg_ack_q), .preload(preload), .pwr_msg(pwr_msg),
        .msi_64bit_cap(msi_64bit_cap), .msi_addr_upper_q(msi_addr_upper_q),
        .msi_data_q(msi_data_q));
    pcr_host_model pcr_host_model_inst (.clk_sys(clk_sys), .cfg_req(cfg_req),
        .cfg_rdata_q(cfg_rdata_q), .cfg_ack_q(cfg_ack_q));

    // Expected header and device capability words
    function automatic logic [31:0] f_hdr(logic u, logic [7:0] np, logic sl);
        return {2'b00, 5'h00, sl & ~u, u ? 4'h5 : 4'h6, 4'h2, np, 8'h10};
    endfunction
    function automatic logic [31:0] f_dev(logic [2:0] m, logic rb, logic [1:0] sc, logic [7:0] v);
        return {4'h0, sc, v, 2'h0, rb, 3'h0, 9'h000, m};
    endfunction
    // Byte-lane merge of a write into the old value
    function automatic logic [31:0] f_merge(logic [31:0] o, logic [31:0] n, logic [3:0] b);
        for (int i = 0; i < 4; i++) begin
            if (b[i]) o[8*i +: 8] = n[8*i +: 8];
        end
        return o;
    endfunction

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        tests_run++;
        if (seen !== expv) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic k;
        pcr_host_model_inst.access(1'b0, a, 4'hf, 32'h0, d, k);
        check({31'h0, k}, 32'h1);
        check(d, e);
    endtask
    task automatic wrchk(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
        pcr_host_model_inst.access(1'b1, a, b, d, rd, ack);
        check({31'h0, ack}, 32'h1);
    endtask
    task automatic do_reset(input logic u);
        @(negedge clk_sys);
        reset_n = 1'b0;
        is_upstream = u;
        repeat (12) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (5) @(negedge clk_sys);
    endtask
    task automatic conclude();
        $display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        $display("watchdog expired");
        conclude();
    end

    // Main sequence, downstream then upstream
    initial begin
        reset_n = 1'b0;
        is_upstream = 1'b0;
        msi_64bit_cap = 1'b1;
        preload = '0;
        pwr_msg = '0;
        for (int u = 0; u < 2; u++) begin
            do_reset(u[0]);
            rdchk(12'h050, 32'h0);
            rdchk(12'h054, 32'h0);
            rdchk(12'h068, f_hdr(u[0], 8'ha4, 1'b1));
            rdchk(12'h06c, f_dev(3'h1, 1'b1, 2'h0, 8'h00));
            $display("test reset values done");
            m_up = 32'h0;
            m_dat = 32'h0;
            for (int i = 0; i < 6; i++) begin
                wd = 32'($random(seed));
                r = 32'($random(seed));
                be = (i == 0) ? 4'hf : r[3:0];
                msi_64bit_cap = i[0];
                wrchk(12'h050, be, wd);
                m_up = f_merge(m_up, wd, be);
                rdchk(12'h050, m_up);
                check(msi_addr_upper_q, i[0] ? m_up : 32'h0);
                wrchk(12'h054, be, ~wd);
                m_dat = f_merge(m_dat, ~wd, be & 4'h3);
                rdchk(12'h054, m_dat);
                check({16'h0, msi_data_q}, m_dat);
            end
            $display("test write lanes done");
            wrchk(12'h068, 4'hf, 32'hffff_ffff);
            wrchk(12'h06c, 4'hf, 32'hffff_ffff);
            wrchk(12'h058, 4'hf, 32'hffff_ffff);
            rdchk(12'h068, f_hdr(u[0], 8'ha4, 1'b1));
            rdchk(12'h06c, f_dev(3'h1, 1'b1, 2'h0, 8'h00));
            rdchk(12'h058, 32'h0);
            rdchk(12'h050, m_up);
            $display("test read-only writes done");
            for (int i = 0; i < 4; i++) begin
                r = 32'($random(seed));
                @(negedge clk_sys);
                preload = {1'b1, r[7:0], r[8], i[2:0], r[9]};
                pwr_msg = {1'b1, r[17:10], r[19:18]};
                @(negedge clk_sys);
                preload.valid = 1'b0;
                pwr_msg.valid = 1'b0;
                rdchk(12'h068, f_hdr(u[0], r[7:0], r[8]));
                rdchk(12'h06c, f_dev((i == 3) ? 3'h1 : i[2:0], r[9], u[0] ? r[19:18] : 2'h0,
                                     u[0] ? r[17:10] : 8'h00));
            end
            $display("test preload and power capture done");
        end
        conclude();
    end
endmodule // pcr_port_capability_regs_tb_top
`default_nettype wire
